// ---- common/tws_regs.vh ----
// register map, field positions and reset values of the three-wire serial port
`ifndef TWS_REGS_VH
`define TWS_REGS_VH

// register indexes as printed; byte address is four times the index
`define TWS_IDX_SHIFT 16'hff1a
`define TWS_IDX_MODE 16'hffb0
`define TWS_IDX_STATUS 16'hffb1
`define TWS_IDX_MASK 16'hffb2
`define TWS_ADDR_W 18

// mode register fields
`define TWS_MODE_EN_BIT 7
`define TWS_MODE_RXONLY_BIT 2
`define TWS_MODE_CLKSEL_HI 1
`define TWS_MODE_CLKSEL_LO 0
`define TWS_MODE_WMASK 8'h87

// clock select codes
`define TWS_CLKSEL_EXT 2'h0
`define TWS_CLKSEL_DIV_A 2'h1
`define TWS_CLKSEL_DIV_B 2'h2
`define TWS_CLKSEL_DIV_C 2'h3

// divider exponents: system clock divided by two to these powers
`define TWS_DIV_EXP_A 3
`define TWS_DIV_EXP_B 4
`define TWS_DIV_EXP_C 6

// status and mask field
`define TWS_STAT_DONE_BIT 0

// reset values
`define TWS_RST_MODE 8'h00
`define TWS_RST_SHIFT 8'h00
`define TWS_RST_STATUS 1'b0
`define TWS_RST_MASK 1'b0

// bits per transfer
`define TWS_BITS 4'h8
`define TWS_PRDATA_ZERO 32'h0000_0000

`endif

// ---- rtl/tws_serial.v ----
// three-wire msb-first serial port with apb register access and completion interrupt
`timescale 1ns/1ps
`include "tws_regs.vh"

module tws_serial #(
  parameter DIV_EXP_A = `TWS_DIV_EXP_A,
  parameter DIV_EXP_B = `TWS_DIV_EXP_B,
  parameter DIV_EXP_C = `TWS_DIV_EXP_C
) (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [`TWS_ADDR_W-1:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error on unmapped address
  input wire serial_clock_pin_in, // clock pin level
  output wire serial_clock_pin_out, // clock pin drive value
  output wire serial_clock_pin_oe_n, // clock pin enable, low drives
  output wire serial_out_pin, // serial data out
  output wire serial_out_pin_oe_n, // data out enable, low drives
  input wire serial_in_pin, // serial data in
  output wire serial_in_active, // high while input pin is used by the port
  output wire irq // level interrupt
);

  localparam [15:0] HALF_A = 16'h0001 << (DIV_EXP_A - 1);
  localparam [15:0] HALF_B = 16'h0001 << (DIV_EXP_B - 1);
  localparam [15:0] HALF_C = 16'h0001 << (DIV_EXP_C - 1);
  localparam [`TWS_ADDR_W-1:0] A_SHIFT = {`TWS_IDX_SHIFT, 2'b00};
  localparam [`TWS_ADDR_W-1:0] A_MODE = {`TWS_IDX_MODE, 2'b00};
  localparam [`TWS_ADDR_W-1:0] A_STATUS = {`TWS_IDX_STATUS, 2'b00};
  localparam [`TWS_ADDR_W-1:0] A_MASK = {`TWS_IDX_MASK, 2'b00};

  reg [7:0] mode_q;
  reg [7:0] shift_q;
  reg [7:0] shift_d;
  reg done_q;
  reg mask_q;
  reg irq_q;
  reg busy_q;
  reg [3:0] count_q;
  reg [15:0] div_q;
  reg sck_q;
  reg so_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg pslverr_q;
  reg sck_s1_q;
  reg sck_s2_q;
  reg sck_s3_q;
  reg sck_lvl_q;
  reg si_s1_q;
  reg si_s2_q;
  reg si_s3_q;
  reg si_lvl_q;
  reg sck_oe_n_q;
  reg so_oe_n_q;
  reg si_act_q;

  wire enable = mode_q[`TWS_MODE_EN_BIT];
  wire rx_only = mode_q[`TWS_MODE_RXONLY_BIT];
  wire [1:0] clk_sel = mode_q[`TWS_MODE_CLKSEL_HI:`TWS_MODE_CLKSEL_LO];
  wire master = (clk_sel != `TWS_CLKSEL_EXT);

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire wr_acc = access & pwrite;
  wire rd_acc = access & ~pwrite;
  wire hit_shift = (paddr == A_SHIFT);
  wire hit_mode = (paddr == A_MODE);
  wire hit_status = (paddr == A_STATUS);
  wire hit_mask = (paddr == A_MASK);
  wire mapped = hit_shift | hit_mode | hit_status | hit_mask;

  // filtered external clock and input: a change counts when stages two and three agree
  wire sck_agree = (sck_s2_q == sck_s3_q);
  wire ext_fall = sck_agree & sck_lvl_q & ~sck_s3_q;
  wire ext_rise = sck_agree & ~sck_lvl_q & sck_s3_q;
  wire si_now = (si_s2_q == si_s3_q) ? si_s3_q : si_lvl_q;

  // master clock tick at the end of each half period
  wire int_tick = busy_q & master & (div_q == 16'h0000);
  wire fall_ev = master ? (int_tick & sck_q) : (busy_q & ext_fall);
  wire rise_ev = master ? (int_tick & ~sck_q) : (busy_q & ext_rise);
  wire last_rise = rise_ev & (count_q == `TWS_BITS - 4'h1);

  // start conditions: enabled, idle, clock at rest high
  wire clk_rest = master ? sck_q : sck_lvl_q;
  wire trig_wr = wr_acc & hit_shift & ~rx_only;
  wire trig_rd = rd_acc & hit_shift & rx_only;
  wire start = enable & ~busy_q & clk_rest & (trig_wr | trig_rd);

  // reload value for the half period divider
  reg [15:0] half_sel;
  always @*
  begin
    case (clk_sel)
      `TWS_CLKSEL_DIV_A: half_sel = HALF_A;
      `TWS_CLKSEL_DIV_B: half_sel = HALF_B;
      `TWS_CLKSEL_DIV_C: half_sel = HALF_C;
      default: half_sel = 16'h0001;
    endcase
  end

  // synchronisers for pin inputs
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      sck_lvl_q <= 1'b1;
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
      si_s3_q <= 1'b0;
      si_lvl_q <= 1'b0;
    end
    else
    begin
      sck_s1_q <= serial_clock_pin_in;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      if (sck_agree)
        sck_lvl_q <= sck_s3_q;
      si_s1_q <= serial_in_pin;
      si_s2_q <= si_s1_q;
      si_s3_q <= si_s2_q;
      si_lvl_q <= si_now;
    end
  end

  // mode, mask and done flag registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= `TWS_RST_MODE;
      mask_q <= `TWS_RST_MASK;
      done_q <= `TWS_RST_STATUS;
      irq_q <= 1'b0;
    end
    else
    begin
      if (wr_acc & hit_mode)
        mode_q <= pwdata[7:0] & `TWS_MODE_WMASK;
      if (wr_acc & hit_mask)
        mask_q <= pwdata[`TWS_STAT_DONE_BIT];
      // completion sets the flag; a set in the clearing cycle wins
      if (last_rise)
        done_q <= 1'b1;
      else if (wr_acc & hit_status & pwdata[`TWS_STAT_DONE_BIT])
        done_q <= 1'b0;
      irq_q <= (done_q | last_rise) & mask_q;
    end
  end

  // next shift register value: shift out on fall, sample in on rise
  always @*
  begin
    shift_d = shift_q;
    if (wr_acc & hit_shift & ~busy_q & ~rx_only)
      shift_d = pwdata[7:0];
    else if (busy_q & enable & fall_ev)
      shift_d = {shift_q[6:0], shift_q[0]};
    else if (busy_q & enable & rise_ev)
      shift_d = {shift_q[7:1], si_now};
  end

  // transfer sequencer: bit counter, divider, internal clock, output latch
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_q <= `TWS_RST_SHIFT;
      busy_q <= 1'b0;
      count_q <= 4'h0;
      div_q <= 16'h0000;
      sck_q <= 1'b1;
      so_q <= 1'b0;
    end
    else if (!enable)
    begin
      // stopped port: no shifting, counter cleared
      busy_q <= 1'b0;
      count_q <= 4'h0;
      div_q <= 16'h0000;
      sck_q <= 1'b1;
      so_q <= 1'b0;
      if (wr_acc & hit_shift)
        shift_q <= pwdata[7:0];
    end
    else
    begin
      shift_q <= shift_d;
      if (start)
      begin
        busy_q <= 1'b1;
        count_q <= 4'h0;
        div_q <= 16'h0000; // first falling edge on next cycle
      end
      else if (busy_q)
      begin
        if (master)
        begin
          if (int_tick)
          begin
            sck_q <= ~sck_q;
            div_q <= half_sel - 16'h0001;
          end
          else
            div_q <= div_q - 16'h0001;
        end
        if (rise_ev)
          count_q <= count_q + 4'h1;
        if (last_rise)
          busy_q <= 1'b0;
      end
      else
        sck_q <= 1'b1;
      // output latch: msb presented on falling edge, low in receive-only
      if (rx_only)
        so_q <= 1'b0;
      else if (busy_q & fall_ev)
        so_q <= shift_q[7];
    end
  end

  // pin enables: released when stopped, per mode when enabled
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_oe_n_q <= 1'b1;
      so_oe_n_q <= 1'b1;
      si_act_q <= 1'b0;
    end
    else
    begin
      sck_oe_n_q <= ~(enable & master);
      so_oe_n_q <= ~(enable & ~rx_only);
      si_act_q <= enable;
    end
  end

  // apb answer registered in setup phase, completes in first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= `TWS_PRDATA_ZERO;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup & ~pwrite)
      begin
        prdata_q <= `TWS_PRDATA_ZERO;
        if (hit_shift)
          prdata_q[7:0] <= shift_q;
        else if (hit_mode)
          prdata_q[7:0] <= mode_q;
        else if (hit_status)
          prdata_q[`TWS_STAT_DONE_BIT] <= done_q;
        else if (hit_mask)
          prdata_q[`TWS_STAT_DONE_BIT] <= mask_q;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_clock_pin_out = sck_q;
  assign serial_clock_pin_oe_n = sck_oe_n_q;
  assign serial_out_pin = so_q;
  assign serial_out_pin_oe_n = so_oe_n_q;
  assign serial_in_active = si_act_q;
  assign irq = irq_q;

endmodule

// ---- verification/tws_properties.sv ----
// assertions on the serial port pins and bus handshake
`timescale 1ns/1ps
module tws_props (
  input wire pclk, // clock
  input wire presetn, // reset, active low
  input wire psel, // select
  input wire penable, // access phase
  input wire pready, // ready
  input wire pslverr, // error
  input wire serial_clock_pin_out, // clock out
  input wire serial_clock_pin_oe_n, // clock drive, low on
  input wire serial_out_pin, // data out
  input wire serial_out_pin_oe_n, // data drive, low on
  input wire serial_in_active // input in use
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus handshake
  a_ready_after_setup:
    assert property (psel && !penable |=> pready) else $error("ready late");
  a_ready_one_cycle:
    assert property (pready |=> !pready) else $error("ready held");
  a_err_with_ready:
    assert property (pslverr |-> pready) else $error("stray error");
  // pin ownership
  a_pins_released:
    assert property (!serial_in_active |-> serial_clock_pin_oe_n && serial_out_pin_oe_n)
      else $error("pins driven");
  a_out_low:
    assert property (serial_out_pin_oe_n |-> !serial_out_pin) else $error("out not low");
  // serial clock and data timing
  a_clk_master_only:
    assert property ($fell(serial_clock_pin_out) |-> !serial_clock_pin_oe_n)
      else $error("slave drove clock");
  a_clk_low_min:
    assert property ($fell(serial_clock_pin_out)
      |=> (!serial_clock_pin_out || serial_clock_pin_oe_n) [*3]) else $error("short low");
  a_shift_on_fall:
    assert property (!serial_clock_pin_oe_n && !$past(serial_out_pin_oe_n) && !serial_out_pin_oe_n
      && $changed(serial_out_pin) |-> $fell(serial_clock_pin_out)) else $error("off-edge shift");
endmodule

bind tws_serial tws_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe_n(serial_clock_pin_oe_n), .serial_out_pin(serial_out_pin),
  .serial_out_pin_oe_n(serial_out_pin_oe_n), .serial_in_active(serial_in_active)
);

// ---- verification/tws_peer.sv ----
// model of an external clocked serial peripheral
`timescale 1ns/1ps
module tws_peer (
  input wire pclk, // system clock
  input wire sck, // resolved clock line
  input wire sdo, // data from the port
  input wire start, // pulse: clock one byte as master
  input wire [7:0] tx, // byte to send
  output reg sdi = 1'b0, // data into the port
  output reg mclk = 1'b1, // clock when the port is slave
  output reg [7:0] rx = 8'h00 // byte captured
);
  reg [2:0] f = 3'h0;
  reg [6:0] k = 7'h00;
  // next bit on each falling edge, msb first
  always @(negedge sck)
  begin
    sdi <= tx[3'd7 - f];
    f <= f + 3'h1;
  end
  // capture what the port sends on each rising edge
  always @(posedge sck)
    rx <= {rx[6:0], sdo};
  // one byte of clock, six cycles a phase, resting high after
  always @(posedge pclk)
    if (start || k != 7'h00)
    begin
      k <= (k == 7'd95) ? 7'h00 : k + 7'h01;
      mclk <= (k % 12) > 5;
    end
endmodule

// ---- verification/tws_tb.sv ----
// self-checking bench for the three-wire serial port
`timescale 1ns/1ps
`include "tws_regs.vh"
module tb;
  localparam [17:0] A_SH = {`TWS_IDX_SHIFT, 2'b00};
  localparam [17:0] A_MD = {`TWS_IDX_MODE, 2'b00};
  localparam [17:0] A_ST = {`TWS_IDX_STATUS, 2'b00};
  localparam [17:0] A_MK = {`TWS_IDX_MASK, 2'b00};
  reg pclk, presetn, psel, penable, pwrite, start, e;
  reg [17:0] paddr;
  reg [31:0] pwdata, r;
  reg [7:0] ptx, md, dv, pv, last;
  reg [23:0] rows [0:4];
  wire [31:0] prdata;
  wire pready, pslverr, ck_o, ck_oe_n, so, so_oe_n, si, si_act, irq, mclk, sck;
  wire [7:0] prx;
  integer miscompares, n_checks, i, n, n16;
  integer cyc = 0;
  // clock line: the port when it drives, else the peer
  assign sck = ck_oe_n ? mclk : ck_o;
  tws_serial u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_pin_in(sck), .serial_clock_pin_out(ck_o),
    .serial_clock_pin_oe_n(ck_oe_n), .serial_out_pin(so), .serial_out_pin_oe_n(so_oe_n),
    .serial_in_pin(si), .serial_in_active(si_act), .irq(irq));
  tws_peer u_peer (.pclk(pclk), .sck(sck), .sdo(so), .start(start), .tx(ptx), .sdi(si),
    .mclk(mclk), .rx(prx));
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // hang guard
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  task apb(input w, input [17:0] a, input [31:0] d);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // look at the answer mid-cycle, where it stands settled
      @(negedge pclk);
      while (pready !== 1'b1)
      begin
        @(posedge pclk);
        @(negedge pclk);
      end
      r = prdata;
      e = pslverr;
      // completing edge, then release
      @(posedge pclk);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
    end
  endtask
  task chk(input [39:0] nm, input [31:0] x, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== x)
      begin
        miscompares = miscompares + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, x, got);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    miscompares = 0; n_checks = 0; last = 0; presetn = 0; psel = 0; penable = 0;
    pwrite = 0; paddr = 0; pwdata = 0; start = 0; ptx = 0;
    // mode, port byte, peer byte
    rows[0] = 24'h81_A53C; rows[1] = 24'h82_0FC1; rows[2] = 24'h83_965A;
    rows[3] = 24'h85_00E7; rows[4] = 24'h80_6924;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("pins", 5'b1_1100, {ck_o, ck_oe_n, so_oe_n, so, irq});
    apb(0, A_MD, 0);
    chk("mode", 0, r);
    apb(0, A_SH, 0);
    chk("shft", 0, r);
    apb(0, 18'h0_0000, 0);
    chk("err", 1, e);
    apb(1, A_MK, 1);
    // every clock choice and both transfer modes
    for (i = 0; i < 5; i = i + 1)
    begin
      {md, dv, pv} = rows[i];
      ptx <= pv;
      // cycles from first fall to eighth rise: fifteen half periods
      n16 = (md[1:0] == 2'd1) ? 60 : (md[1:0] == 2'd2) ? 120 : 480;
      apb(1, A_MD, md);
      chk("mdwr", 0, e);
      apb(0, A_MD, 0);
      chk("mode", md, r);
      apb(!md[2], A_SH, dv);
      if (md[2])
        chk("prev", last, r);
      if (md[1:0] == 2'd0)
      begin
        start <= 1;
        @(posedge pclk);
        start <= 0;
      end
      // shift register left alone until the flag comes
      n = 0;
      while (irq !== 1'b1)
      begin
        @(negedge pclk);
        n = n + 1;
      end
      @(posedge pclk);
      if (md[1:0] != 2'd0)
        chk("time", 1, (n > n16 - 3) && (n < n16 + 3));
      chk("peer", md[2] ? 8'h00 : dv, prx);
      apb(1, A_MD, md & 8'h83);
      apb(0, A_SH, 0);
      chk("rx", pv, r);
      apb(1, A_ST, 1);
      @(posedge pclk);
      chk("clr", 0, irq);
      last = pv;
    end
    // a byte stored while disabled never starts later
    apb(1, A_MD, 8'h00);
    apb(1, A_SH, 8'hC3);
    apb(1, A_MD, 8'h81);
    repeat (80) @(posedge pclk);
    apb(0, A_ST, 0);
    chk("nost", 0, r);
    // masked completion, then unmask and clear
    apb(1, A_MK, 0);
    apb(1, A_SH, 8'hC3);
    repeat (80) @(posedge pclk);
    apb(0, A_ST, 0);
    chk("done", 1, r);
    chk("mskd", 0, irq);
    apb(1, A_MK, 1);
    @(posedge pclk);
    chk("irq", 1, irq);
    apb(1, A_ST, 1);
    @(posedge pclk);
    chk("irq", 0, irq);
    // disable in mid-byte
    apb(1, A_SH, 8'h5A);
    repeat (20) @(posedge pclk);
    apb(1, A_MD, 0);
    @(posedge pclk);
    chk("rel", 4'b1110, {ck_o, ck_oe_n, so_oe_n, si_act});
    repeat (80) @(posedge pclk);
    apb(0, A_ST, 0);
    chk("abrt", 0, r);
    stop_test;
  end
endmodule
